/* verilog/jtg_pkg.sv */
package jtg_pkg;
    // -------------------------------------------------------------
    // Instruction register
    // -------------------------------------------------------------
    localparam int IR_W = 10;
    localparam logic [IR_W-1:0] INS_SAMPLE = 10'h005;
    localparam logic [IR_W-1:0] INS_EXTEST = 10'h00F;
    localparam logic [IR_W-1:0] INS_BYPASS = 10'h3FF;
    localparam logic [IR_W-1:0] INS_USERCODE = 10'h007;
    localparam logic [IR_W-1:0] INS_IDENT = 10'h006;
    localparam logic [IR_W-1:0] INS_HIGHZ = 10'h00B;
    localparam logic [IR_W-1:0] INS_USER_A = 10'h00C;
    localparam logic [IR_W-1:0] INS_USER_B = 10'h00E;
    localparam logic [IR_W-1:0] INS_ISP_ENTER = 10'h2CC;
    localparam logic [IR_W-1:0] INS_ISP_EXIT = 10'h201;
    localparam logic [IR_W-1:0] INS_ISP_ADDR = 10'h203;
    localparam logic [IR_W-1:0] INS_ISP_ERASE = 10'h2F2;
    localparam logic [IR_W-1:0] INS_ISP_PROGRAM = 10'h2F4;
    localparam logic [IR_W-1:0] INS_ISP_VERIFY = 10'h2F5;
    // Capture pattern of the instruction register
    localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;

    // -------------------------------------------------------------
    // Data registers and flash geometry
    // -------------------------------------------------------------
    localparam int ID_W = 32;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 10;
    localparam int SECT_W = 7;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
    localparam logic [ADDR_W-1:0] CFG_ADDR = 10'h000;
    localparam logic [ADDR_W-1:0] DONE_ADDR = 10'h07F;
    localparam int DONE_BIT = 0;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int ERASE_MS = 500;
    localparam int PROG_US = 75;
    localparam int ERASE_CYC = ERASE_MS * (CLK_HZ / 1000);
    localparam int PROG_CYC = PROG_US * (CLK_HZ / 1_000_000);

    // -------------------------------------------------------------
    // States
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jtg_tap_t;

    typedef enum {
        CORE_LOAD0, CORE_LOAD1, CORE_LOAD2, CORE_RUN, CORE_SWEEP
    } jtg_core_t;
endpackage : jtg_pkg

/* verilog/jtg_mem_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface jtg_mem_if #(
    parameter int AW = 10,
    parameter int DW = 16
);
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface : jtg_mem_if
`default_nettype wire

/* verilog/jtg_flash.sv */
`timescale 1ns/100ps
`default_nettype none
module jtg_flash #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input wire logic core_clk,
    jtg_mem_if.mem port
);
    logic [DW-1:0] cells [0:(1<<AW)-1];
    logic [DW-1:0] rdata;

    // Non-volatile array, written one word at a time
    always_ff @(posedge core_clk) begin
        if (port.we) begin
            cells[port.addr] <= port.wdata;
        end
    end

    // Registered read port
    always_ff @(posedge core_clk) begin
        rdata <= cells[port.addr];
    end

    assign port.rdata = rdata;
endmodule : jtg_flash
`default_nettype wire

/* verilog/jtg_isp_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module jtg_isp_ctrl
    import jtg_pkg::*;
#(
    parameter int NIO = 8,
    parameter int ERASE_CYCLES = ERASE_CYC,
    parameter int PROG_CYCLES = PROG_CYC,
    parameter logic [ID_W-1:0] ID_VALUE = 32'h0ABC_D001, // arbitrary value
    parameter logic [ID_W-1:0] USERCODE = 32'hFFFF_FFFF
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    input wire logic usr_tdo_a,
    input wire logic usr_tdo_b,
    output logic usr_sel_a,
    output logic usr_sel_b,
    output logic usr_tdi,
    output logic usr_tck,
    output logic usr_tms,
    output jtg_pkg::jtg_tap_t usr_tap_state,
    input wire logic [NIO-1:0] user_out,
    input wire logic [NIO-1:0] user_oe_n,
    input wire logic clamp_en,
    input wire logic [NIO-1:0] clamp_out,
    input wire logic [NIO-1:0] clamp_oe_n,
    input wire logic rt_isp_en,
    output logic [NIO-1:0] pin_out,
    output logic [NIO-1:0] pin_oe_n,
    output logic pin_pullup,
    output logic [DATA_W-1:0] cfg_elements,
    output logic user_mode,
    output logic programming_complete_flag,
    output logic in_system_programming
);
    import jtg_pkg::*;

    // Refuse parameters the logic cannot serve
    if (NIO < 1 || ERASE_CYCLES < 1 || PROG_CYCLES < 1 || ID_VALUE[0] != 1'b1) begin
        $error("jtg_isp_ctrl: bad parameter");
    end

    // -----------------------------------------------------------------
    // Pin synchronisers and TCK edges
    // -----------------------------------------------------------------
    logic [1:0] tck_sync, tms_sync, tdi_sync;
    logic tck_prev;
    logic tck_rise, tck_fall;

    // Two flops on each of tck, tms and tdi before use
    always_ff @(posedge core_clk) begin
        tck_sync <= {tck_sync[0], tck};
        tms_sync <= {tms_sync[0], tms};
        tdi_sync <= {tdi_sync[0], tdi};
        tck_prev <= tck_sync[1];
    end

    assign tck_rise = tck_sync[1] & ~tck_prev;
    assign tck_fall = ~tck_sync[1] & tck_prev;

    // -----------------------------------------------------------------
    // TAP state machine
    // -----------------------------------------------------------------
    function automatic jtg_tap_t tap_next(input jtg_tap_t s, input logic m);
        case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction : tap_next

    // Length of the data register behind an instruction
    function automatic int dr_len(input logic [IR_W-1:0] ins);
        case (ins)
            INS_IDENT, INS_USERCODE: dr_len = ID_W;
            INS_ISP_ADDR: dr_len = ADDR_W;
            INS_ISP_PROGRAM, INS_ISP_VERIFY: dr_len = DATA_W;
            default: dr_len = 1;
        endcase
    endfunction : dr_len

    jtg_tap_t tap;

    // State advances on each sampled TCK rise
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tap <= TAP_RESET;
        end else if (tck_rise) begin
            tap <= tap_next(tap, tms_sync[1]);
        end
    end

    // -----------------------------------------------------------------
    // Instruction and data shift registers
    // -----------------------------------------------------------------
    logic [IR_W-1:0] ir_sr, ir;
    logic [ID_W-1:0] dr_sr;
    logic [ADDR_W-1:0] isp_addr;
    logic [DATA_W-1:0] isp_data, rd_hold;
    logic user_chain;

    assign user_chain = (ir == INS_USER_A) || (ir == INS_USER_B);

    // Instruction register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ir_sr <= IR_CAPTURE;
            ir <= INS_IDENT;
        end else if (tck_rise) begin
            case (tap)
                TAP_RESET: ir <= INS_IDENT;
                TAP_CAP_IR: ir_sr <= IR_CAPTURE;
                TAP_SHIFT_IR: ir_sr <= {tdi_sync[1], ir_sr[IR_W-1:1]};
                TAP_UPD_IR: ir <= ir_sr;
                default: ir <= ir;
            endcase
        end
    end

    // Data register: identifier, user code, address, flash data
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dr_sr <= '0;
        end else if (tck_rise && tap == TAP_CAP_DR) begin
            case (ir)
                INS_IDENT: dr_sr <= ID_VALUE;
                INS_USERCODE: dr_sr <= USERCODE;
                INS_ISP_VERIFY: dr_sr <= {{(ID_W-DATA_W){1'b0}}, rd_hold};
                default: dr_sr <= '0;
            endcase
        end else if (tck_rise && tap == TAP_SHIFT_DR) begin
            dr_sr <= dr_sr >> 1;
            dr_sr[dr_len(ir)-1] <= tdi_sync[1];
        end
    end

    // Address and data latched on Update-DR
    always_ff @(posedge core_clk) begin
        if (reset) begin
            isp_addr <= '0;
            isp_data <= ERASED_WORD;
        end else if (tck_rise && tap == TAP_UPD_DR && in_system_programming) begin
            if (ir == INS_ISP_ADDR) begin
                isp_addr <= dr_sr[ADDR_W-1:0];
            end
            if (ir == INS_ISP_PROGRAM) begin
                isp_data <= dr_sr[DATA_W-1:0];
            end
        end
    end

    // Programming mode entry and exit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            in_system_programming <= 1'b0;
        end else if (tck_rise && tap == TAP_UPD_IR) begin
            if (ir_sr == INS_ISP_ENTER) begin
                in_system_programming <= 1'b1;
            end else if (ir_sr == INS_ISP_EXIT) begin
                in_system_programming <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // TDO on falling TCK
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            tdo_oe_n <= !(tap == TAP_SHIFT_IR || tap == TAP_SHIFT_DR);
            if (tap == TAP_SHIFT_IR) begin
                tdo <= ir_sr[0];
            end else if (ir == INS_USER_A) begin
                tdo <= usr_tdo_a;
            end else if (ir == INS_USER_B) begin
                tdo <= usr_tdo_b;
            end else begin
                tdo <= dr_sr[0];
            end
        end
    end

    // User chain taps
    always_ff @(posedge core_clk) begin
        if (reset) begin
            usr_sel_a <= 1'b0;
            usr_sel_b <= 1'b0;
            usr_tdi <= 1'b0;
            usr_tck <= 1'b0;
            usr_tms <= 1'b0;
            usr_tap_state <= TAP_RESET;
        end else begin
            usr_sel_a <= (ir == INS_USER_A);
            usr_sel_b <= (ir == INS_USER_B);
            usr_tdi <= user_chain & tdi_sync[1];
            usr_tck <= user_chain & tck_sync[1];
            usr_tms <= user_chain & tms_sync[1];
            usr_tap_state <= user_chain ? tap : TAP_RESET;
        end
    end

    // -----------------------------------------------------------------
    // Flash sequencing: power-up load, pulses, erase sweep
    // -----------------------------------------------------------------
    jtg_mem_if #(.AW(ADDR_W), .DW(DATA_W)) mem ();

    jtg_core_t core;
    logic [31:0] dwell;
    logic pulse_done;
    logic [ADDR_W-1:0] sweep;
    logic [SECT_W-1:0] sweep_lo;
    logic dwell_op;

    assign dwell_op = in_system_programming && tap == TAP_IDLE
        && (ir == INS_ISP_ERASE || ir == INS_ISP_PROGRAM);
    assign sweep_lo = sweep[SECT_W-1:0];

    // Pulse timer counts dwell in Run-Test/Idle
    always_ff @(posedge core_clk) begin
        if (reset || !dwell_op) begin
            dwell <= '0;
            pulse_done <= 1'b0;
        end else if (!pulse_done) begin
            dwell <= dwell + 32'd1;
            if (ir == INS_ISP_ERASE && dwell == 32'(ERASE_CYCLES - 1)) begin
                pulse_done <= 1'b1;
            end
            if (ir == INS_ISP_PROGRAM && dwell == 32'(PROG_CYCLES - 1)) begin
                pulse_done <= 1'b1;
            end
        end
    end

    // Core sequencer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            core <= CORE_LOAD0;
            sweep <= '0;
            user_mode <= 1'b0;
            cfg_elements <= '0;
            programming_complete_flag <= 1'b0;
        end else begin
            case (core)
                CORE_LOAD0: core <= CORE_LOAD1;
                CORE_LOAD1: begin
                    cfg_elements <= mem.rdata;
                    core <= CORE_LOAD2;
                end
                CORE_LOAD2: begin
                    programming_complete_flag <= !mem.rdata[DONE_BIT];
                    user_mode <= 1'b1;
                    core <= CORE_RUN;
                end
                CORE_RUN: begin
                    if (dwell_op && ir == INS_ISP_ERASE && dwell == 32'(ERASE_CYCLES - 1)) begin
                        sweep <= {isp_addr[ADDR_W-1:SECT_W], {SECT_W{1'b0}}};
                        core <= CORE_SWEEP;
                        if (isp_addr[ADDR_W-1:SECT_W] == DONE_ADDR[ADDR_W-1:SECT_W]) begin
                            programming_complete_flag <= 1'b0;
                        end
                    end
                    if (dwell_op && ir == INS_ISP_PROGRAM && dwell == 32'(PROG_CYCLES - 1)
                        && isp_addr == DONE_ADDR && !isp_data[DONE_BIT]) begin
                        programming_complete_flag <= 1'b1;
                    end
                end
                CORE_SWEEP: begin
                    sweep <= sweep + 1'b1;
                    if (&sweep_lo) begin
                        core <= CORE_RUN;
                    end
                end
                default: core <= CORE_LOAD0;
            endcase
        end
    end

    // Flash port steering
    always_comb begin
        mem.we = 1'b0;
        mem.wdata = isp_data;
        mem.addr = isp_addr;
        case (core)
            CORE_LOAD0: mem.addr = CFG_ADDR;
            CORE_LOAD1: mem.addr = DONE_ADDR;
            CORE_SWEEP: begin
                mem.we = 1'b1;
                mem.addr = sweep;
                mem.wdata = ERASED_WORD;
            end
            default: begin
                mem.we = dwell_op && ir == INS_ISP_PROGRAM
                    && dwell == 32'(PROG_CYCLES - 1) && !pulse_done;
            end
        endcase
    end

    // Read sampled on every core cycle spent in Run-Test/Idle under verify
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_hold <= ERASED_WORD;
        end else if (in_system_programming && ir == INS_ISP_VERIFY && tap == TAP_IDLE) begin
            rd_hold <= mem.rdata;
        end
    end

    jtg_flash #(.AW(ADDR_W), .DW(DATA_W)) u_flash (
        .core_clk(core_clk),
        .port(mem.mem)
    );

    // -----------------------------------------------------------------
    // User I/O pin control
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_out <= '0;
            pin_oe_n <= '1;
            pin_pullup <= 1'b1;
        end else if (!user_mode || !programming_complete_flag || ir == INS_HIGHZ) begin
            pin_out <= '0;
            pin_oe_n <= '1;
            pin_pullup <= 1'b1;
        end else if (in_system_programming && !rt_isp_en) begin
            pin_out <= clamp_en ? clamp_out : '0;
            pin_oe_n <= clamp_en ? clamp_oe_n : '1;
            pin_pullup <= !clamp_en;
        end else begin
            pin_out <= user_out;
            pin_oe_n <= user_oe_n;
            pin_pullup <= 1'b0;
        end
    end
endmodule : jtg_isp_ctrl
`default_nettype wire

/* dv/jtg_isp_ctrl_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module jtg_isp_ctrl_chk
    import jtg_pkg::*;
#(
    parameter int NIO = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    input wire logic usr_sel_a,
    input wire logic usr_sel_b,
    input wire logic usr_tck,
    input wire jtg_pkg::jtg_tap_t usr_tap_state,
    input wire logic clamp_en,
    input wire logic [NIO-1:0] clamp_oe_n,
    input wire logic rt_isp_en,
    input wire logic [NIO-1:0] pin_oe_n,
    input wire logic pin_pullup,
    input wire logic user_mode,
    input wire logic programming_complete_flag,
    input wire logic in_system_programming
);
    // -------------------------------------------------------------
    // Port relations
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_sel;
        !(usr_sel_a && usr_sel_b);
    endproperty
    a_sel: assert property (p_sel) else $error("both user chains selected");
    property p_usr;
        (!usr_sel_a && !usr_sel_b) [*2] |-> !usr_tck && usr_tap_state == TAP_RESET;
    endproperty
    a_usr: assert property (p_usr) else $error("user tap signals leak");
    property p_flag;
        !programming_complete_flag |=> &pin_oe_n && pin_pullup;
    endproperty
    a_flag: assert property (p_flag) else $error("pins drive before done");
    property p_isp;
        in_system_programming && !rt_isp_en && !clamp_en |=> &pin_oe_n && pin_pullup;
    endproperty
    a_isp: assert property (p_isp) else $error("pins not floating");
    property p_clamp;
        programming_complete_flag && user_mode && in_system_programming && !rt_isp_en
            && clamp_en |=> pin_oe_n == $past(clamp_oe_n);
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp not applied");
    property p_load;
        $fell(reset) |-> !user_mode ##[1:4] user_mode;
    endproperty
    a_load: assert property (p_load) else $error("power-up load timing");
    property p_pwr;
        !user_mode |=> &pin_oe_n;
    endproperty
    a_pwr: assert property (p_pwr) else $error("pins drive before load");
    property p_tdo;
        $changed(tdo) |-> $past(tck, 4) && !$past(tck, 3);
    endproperty
    a_tdo: assert property (p_tdo) else $error("tdo moved off tck fall");
    property p_oe;
        $fell(tdo_oe_n) |-> $past(tck, 4) && !$past(tck, 3);
    endproperty
    a_oe: assert property (p_oe) else $error("tdo enable off tck fall");
endmodule : jtg_isp_ctrl_chk

bind jtg_isp_ctrl jtg_isp_ctrl_chk #(.NIO(NIO)) u_chk (.core_clk(core_clk), .reset(reset),
    .tck(tck), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .usr_sel_a(usr_sel_a), .usr_sel_b(usr_sel_b),
    .usr_tck(usr_tck), .usr_tap_state(usr_tap_state), .clamp_en(clamp_en),
    .clamp_oe_n(clamp_oe_n), .rt_isp_en(rt_isp_en), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .user_mode(user_mode),
    .programming_complete_flag(programming_complete_flag),
    .in_system_programming(in_system_programming));
`default_nettype wire

/* dv/jtg_prog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module jtg_prog_model (
    input wire logic core_clk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    // Link idles with tck high and still
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One tck period, 4 core cycles each phase; tdo read before the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge core_clk);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(negedge core_clk);
        q = tdo;
        tck = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask : step
    // Five ones reach Test-Logic-Reset, then Run-Test/Idle
    task automatic go_reset();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : go_reset
    // Idle to idle IR or DR scan, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~din[0], q);
        if (ir) begin
            step(1'b1, din[0], q);
        end
        step(1'b0, ~din[0], q);
        step(1'b0, din[0], q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~din[n-1], q);
        step(1'b0, din[n-1], q);
    endtask : scan
endmodule : jtg_prog_model
`default_nettype wire

/* dv/jtg_isp_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module jtg_isp_ctrl_tb;
    import jtg_pkg::*;
    localparam int EC = 20;
    localparam int PC = 5;
    localparam logic [31:0] ID = 32'h1357_9BDF; // arbitrary value
    logic core_clk, reset, usr_tdo_a, usr_tdo_b, clamp_en, rt_isp_en;
    logic [7:0] user_out, user_oe_n, clamp_out, clamp_oe_n, pin_out, pin_oe_n;
    logic tdo, tdo_oe_n, usr_sel_a, usr_sel_b, usr_tdi, usr_tck, usr_tms, pin_pullup;
    logic user_mode, flag, isp;
    logic [15:0] cfg_elements;
    jtg_tap_t usr_tap_state;
    wire logic tck, tms, tdi;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] d;
    jtg_isp_ctrl #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC), .ID_VALUE(ID)) uut (
        .core_clk(core_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .usr_tdo_a(usr_tdo_a), .usr_tdo_b(usr_tdo_b),
        .usr_sel_a(usr_sel_a), .usr_sel_b(usr_sel_b), .usr_tdi(usr_tdi), .usr_tck(usr_tck),
        .usr_tms(usr_tms), .usr_tap_state(usr_tap_state), .user_out(user_out),
        .user_oe_n(user_oe_n), .clamp_en(clamp_en), .clamp_out(clamp_out),
        .clamp_oe_n(clamp_oe_n), .rt_isp_en(rt_isp_en), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .cfg_elements(cfg_elements),
        .user_mode(user_mode), .programming_complete_flag(flag),
        .in_system_programming(isp));
    jtg_prog_model u_prog (.core_clk(core_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wt
    task automatic ir(input logic [9:0] c);
        logic [31:0] q;
        u_prog.scan(1'b1, 10, {22'h0, c}, q);
    endtask : ir
    task automatic dr(input int n, input logic [31:0] din);
        u_prog.scan(1'b0, n, din, d);
    endtask : dr
    task automatic prog_word(input logic [9:0] a, input logic [15:0] v);
        ir(INS_ISP_ADDR);
        dr(10, {22'h0, a});
        ir(INS_ISP_PROGRAM);
        dr(16, {16'h0, v});
        wt(PC + 4);
    endtask : prog_word
    task automatic rd_word(input logic [9:0] a);
        ir(INS_ISP_ADDR);
        dr(10, {22'h0, a});
        ir(INS_ISP_VERIFY);
        wt(4);
        dr(16, 32'h0);
    endtask : rd_word
    task automatic enter_id();
        ir(INS_ISP_ENTER);
        wt(3);
        chk(isp, 1);
        ir(INS_IDENT);
        dr(32, 32'h0);
        chk(d, ID);
    endtask : enter_id
    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_power();
        chk(cfg_elements, 32'h1234);
        chk(flag, 1);
        chk(pin_oe_n, 8'h00);
        chk(pin_out, 8'h5A);
        u_prog.go_reset();
        dr(32, 32'h0);
        chk(d, ID);
        chk(d[0], 1);
        u_prog.scan(1'b1, 10, {22'h0, INS_BYPASS}, d);
        chk(d[9:0], IR_CAPTURE);
        ir(INS_USERCODE);
        dr(32, 32'h0);
        chk(d, 32'hFFFF_FFFF);
        ir(INS_HIGHZ);
        wt(2);
        chk(pin_oe_n, 8'hFF);
        chk(pin_pullup, 1);
        $display("t_power done");
    endtask : t_power
    task automatic t_user();
        logic q;
        for (int k = 0; k < 2; k++) begin
            ir(k == 0 ? INS_USER_A : INS_USER_B);
            wt(2);
            chk(usr_sel_a, k == 0);
            chk(usr_sel_b, k == 1);
            chk(usr_tap_state, TAP_IDLE);
            chk(usr_tck, 1);
            dr(8, 32'h80);
            chk(d, k == 0 ? 32'hFF : 32'h00);
            chk(usr_tdi, 1);
            u_prog.step(1'b1, 1'b0, q);
            wt(2);
            chk(usr_tms, 1);
            chk(usr_tap_state, TAP_SEL_DR);
            u_prog.go_reset();
        end
        ir(INS_BYPASS);
        wt(3);
        chk(usr_tap_state, TAP_RESET);
        $display("t_user done");
    endtask : t_user
    task automatic t_full();
        enter_id();
        chk(pin_oe_n, 8'hFF);
        chk(pin_pullup, 1);
        clamp_en = 1'b1;
        wt(3);
        chk(pin_oe_n, 8'h0F);
        chk(pin_out, 8'h33);
        clamp_en = 1'b0;
        rt_isp_en = 1'b1;
        wt(3);
        chk(pin_oe_n, 8'h00);
        ir(INS_ISP_ADDR);
        dr(10, 32'h0);
        ir(INS_ISP_ERASE);
        wt(EC + 140);
        chk(flag, 0);
        chk(pin_oe_n, 8'hFF);
        prog_word(10'h005, 16'hA5C3);
        prog_word(DONE_ADDR, 16'hFFFE);
        chk(flag, 1);
        rd_word(10'h005);
        chk(d, 32'hA5C3);
        rd_word(CFG_ADDR);
        chk(d, ERASED_WORD);
        rt_isp_en = 1'b0;
        user_out = 8'hC3;
        ir(INS_ISP_EXIT);
        wt(3);
        chk(isp, 0);
        chk(pin_oe_n, 8'h00);
        chk(pin_out, 8'hC3);
        $display("t_full done");
    endtask : t_full
    task automatic t_verify();
        prog_word(10'h005, 16'h0000);
        enter_id();
        rd_word(10'h005);
        chk(d, 32'hA5C3);
        ir(INS_ISP_EXIT);
        wt(3);
        chk(isp, 0);
        $display("t_verify done");
    endtask : t_verify
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            results();
        end
    end
    // Main sequence
    initial begin
        {reset, usr_tdo_a, usr_tdo_b, clamp_en, rt_isp_en} = 5'b11000;
        {user_out, user_oe_n, clamp_out, clamp_oe_n} = 32'h5A00_330F;
        for (int i = 0; i < 1024; i++) begin
            uut.u_flash.cells[i] = ERASED_WORD;
        end
        uut.u_flash.cells[CFG_ADDR] = 16'h1234;
        uut.u_flash.cells[DONE_ADDR] = 16'hFFFE;
        wt(4);
        reset = 1'b0;
        wt(8);
        chk(user_mode, 1);
        t_power();
        t_user();
        t_full();
        t_verify();
        results();
    end
endmodule : jtg_isp_ctrl_tb
`default_nettype wire
